// *** bench/front_panel_model.sv ***
module front_panel_model (
   input  wire logic clock,
   output logic      powerSwitch_n,
   output logic [6:0] wakeIn
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      powerSwitch_n = 1'b1;
      wakeIn = 7'h00;
   end
   // Clean contacts only; bounce would just stretch the debounce wait
   task automatic press(input int n);
      @(posedge clock);
      powerSwitch_n <= 1'b0;
      repeat (n) @(posedge clock);
      powerSwitch_n <= 1'b1;
      repeat (24) @(posedge clock);
   endtask : press
   task automatic wake(input int i);
      @(posedge clock);
      wakeIn[i] <= 1'b1;
      repeat (4) @(posedge clock);
      wakeIn[i] <= 1'b0;
      repeat (8) @(posedge clock);
   endtask : wake
endmodule : front_panel_model

// *** bench/pwr_monitor.sv ***
module pwr_monitor (
   input wire logic       clock,
   input wire logic       rst_n,
   input wire logic [2:0] sleepCode,
   input wire logic       stopGrant,
   input wire logic       selfRefresh,
   input wire logic       diskContext,
   input wire logic       coldBoot,
   input wire logic       devicePowerOn,
   input wire logic       wakeLogicPowerOn,
   input wire logic       coverClosed,
   input wire logic       intrusion,
   input wire logic       linkUp,
   input wire logic       linkLedGreen,
   input wire logic       speed100,
   input wire logic       speedLedYellow
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // Four quiet cycles cover the two sync stages; the LEDs come straight from the B stage, with no output register
   sequence s_noLink; !linkUp [*4]; endsequence
   sequence s_fast; speed100 [*4]; endsequence
   sequence s_slow; !speed100 [*4]; endsequence
   property p_dev; devicePowerOn == (sleepCode <= 3'd1); endproperty
   property p_wake; wakeLogicPowerOn; endproperty
   property p_stop; stopGrant == (sleepCode == 3'd1); endproperty
   property p_self; selfRefresh == (sleepCode == 3'd3); endproperty
   property p_disk; diskContext == (sleepCode == 3'd4); endproperty
   property p_intr; $rose(coverClosed) |-> ##[1:4] intrusion; endproperty
   property p_cold;
      coldBoot |-> sleepCode == 3'd0 && $past(sleepCode) == 3'd5;
   endproperty
   property p_green; s_noLink |-> !linkLedGreen; endproperty
   property p_fast; s_fast |-> speedLedYellow; endproperty
   property p_slow; s_slow |-> !speedLedYellow; endproperty
   a_dev: assert property (p_dev)
      else $error("device power wrong for state");
   a_wake: assert property (p_wake)
      else $error("wake logic unpowered");
   a_stop: assert property (p_stop)
      else $error("stop grant wrong");
   a_self: assert property (p_self)
      else $error("memory context wrong");
   a_disk: assert property (p_disk)
      else $error("disk context wrong");
   a_cold: assert property (p_cold)
      else $error("cold boot flag without leaving soft-off");
   a_intr: assert property (p_intr)
      else $error("intrusion not reported");
   a_green: assert property (p_green)
      else $error("green lit without link");
   a_fast: assert property (p_fast)
      else $error("yellow off at fast rate");
   a_slow: assert property (p_slow)
      else $error("yellow on at slow rate");
endmodule : pwr_monitor

bind power_button_wake_control pwr_monitor u_mon (.*);

// *** bench/tb_top.sv ***
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clock, rst_n, psel, penable, pwrite, pready, pslverr, err;
   logic        linkUp, linkActivity, speed100, coverClosed, powerSwitch_n;
   logic        selfRefresh, irq, en, stopGrant, diskContext, coldBoot;
   logic        devicePowerOn, wakeLogicPowerOn, linkLedGreen;
   logic        speedLedYellow, intrusion;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [39:0] railLevel;
   logic [23:0] tempLevel, fanDrive;
   logic [6:0]  wakeIn;
   logic [4:0]  railFault;
   logic [2:0]  sleepCode, code;
   int          fail_count, compares, tgt;
   always #25 clock = ~clock;
   power_button_wake_control #(.LONG_PRESS_CYCLES(200), .DEBOUNCE_CYCLES(8),
      .BLINK_CYCLES(16)) u_dut (.*);
   front_panel_model u_panel (.*);
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input int d);
      @(posedge clock);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      repeat (3) @(posedge clock);
   endtask : apb
   task automatic end_of_test();
      if (fail_count == 0 && compares > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : end_of_test
   function automatic logic wakeOk(logic [2:0] c, int s, logic e);
      return s < 2 || (s < 4 && (c != 3'd5 || e)) || c < 3'd4;
   endfunction : wakeOk
   function automatic logic [7:0] fanExp(logic [7:0] t);
      if (t <= 8'h28) return 8'h00;
      if (t >= 8'h50) return 8'hff;
      return 8'((t - 8'h28) * 4);
   endfunction : fanExp
   initial begin
      repeat (40000) @(posedge clock);
      fail_count++;
      end_of_test();
   end
   initial begin
      {clock, rst_n, psel, penable, pwrite, linkUp, linkActivity} = '0;
      {speed100, coverClosed, paddr, pwdata, railLevel, tempLevel} = '0;
      fail_count = 0;
      compares = 0;
      void'($urandom(2));
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      chk(sleepCode, 3'd5);
      apb(1'b1, pwr_ctrl_pkg::INT_EN_OFF, 8);
      apb(1'b1, pwr_ctrl_pkg::CTRL_OFF, 2);
      u_panel.press(20);
      chk(sleepCode, 3'd0);
      u_panel.press(20);
      chk(sleepCode, 3'd3);
      u_panel.press(230);
      chk(sleepCode, 3'd5);
      chk(irq, 1'b1);
      apb(1'b1, pwr_ctrl_pkg::INT_CLR_OFF, 8);
      chk(irq, 1'b0);
      apb(1'b0, 8'h40, 0);
      // The error flag and the data are compared apart, so neither is cut
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      u_panel.press(20);
      u_panel.press(230);
      chk(sleepCode, 3'd5);
      u_panel.press(230);
      chk(sleepCode, 3'd5);
      u_panel.press(20);
      for (int k = 0; k < 8; k++) begin
         tgt = k % 4;
         en = k / 4;
         code = (tgt == 0) ? 3'd1 : 3'(tgt + 2);
         apb(1'b1, pwr_ctrl_pkg::CTRL_OFF, tgt * 2 + en);
         for (int s = 0; s < 7; s++) begin
            apb(1'b1, pwr_ctrl_pkg::CMD_OFF, (tgt == 3) ? 2 : 1);
            chk(sleepCode, code);
            chk({stopGrant, selfRefresh, diskContext, devicePowerOn,
                 wakeLogicPowerOn}, {code == 3'd1, code == 3'd3,
                 code == 3'd4, code == 3'd1, 1'b1});
            u_panel.wake(s);
            chk(sleepCode, wakeOk(code, s, en) ? 3'd0 : code);
            if (sleepCode !== 3'd0) u_panel.press(20);
            chk(sleepCode, 3'd0);
         end
      end
      // Rail 0 gets a narrow window so random levels land on both sides
      apb(1'b1, pwr_ctrl_pkg::RAIL_WIN_OFF, 32'h2010);
      for (int i = 0; i < 30; i++) begin
         railLevel <= 40'({$urandom, $urandom});
         tempLevel <= 24'($urandom);
         {coverClosed, linkUp, linkActivity, speed100} <= 4'($urandom);
         repeat (6) @(posedge clock);
         chk(railFault, {4'h0, railLevel[7:0] < 8'h10 ||
             railLevel[7:0] > 8'h20});
         chk(fanDrive, {fanExp(tempLevel[23:16]), fanExp(tempLevel[15:8]),
             fanExp(tempLevel[7:0])});
         chk({intrusion, speedLedYellow}, {coverClosed, speed100});
         if (!linkUp) chk(linkLedGreen, 1'b0);
      end
      end_of_test();
   end
endmodule : tb_top

// *** verilog/power_button_wake_control.sv ***
module power_button_wake_control #(
   parameter int LONG_PRESS_CYCLES = pwr_ctrl_pkg::LONG_PRESS_CYCLES,
   parameter int DEBOUNCE_CYCLES   = pwr_ctrl_pkg::DEBOUNCE_CYCLES,
   parameter int BLINK_CYCLES      = pwr_ctrl_pkg::BLINK_CYCLES
) (
   input  wire logic        clock,
   input  wire logic        rst_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        powerSwitch_n,
   input  wire logic [6:0]  wakeIn,
   input  wire logic        linkUp,
   input  wire logic        linkActivity,
   input  wire logic        speed100,
   input  wire logic        coverClosed,
   input  wire logic [39:0] railLevel,
   input  wire logic [23:0] tempLevel,
   output logic [2:0]       sleepCode,
   output logic             stopGrant,
   output logic             selfRefresh,
   output logic             diskContext,
   output logic             coldBoot,
   output logic             devicePowerOn,
   output logic             wakeLogicPowerOn,
   output logic             linkLedGreen,
   output logic             speedLedYellow,
   output logic             intrusion,
   output logic [4:0]       railFault,
   output logic [23:0]      fanDrive,
   output logic             irq
);
   localparam int NR = pwr_ctrl_pkg::NUM_RAILS;
   localparam int NF = pwr_ctrl_pkg::NUM_FANS;
   localparam int LW = pwr_ctrl_pkg::LEVEL_W;
   localparam int NW = pwr_ctrl_pkg::WAKE_SOURCES;
   localparam int NI = pwr_ctrl_pkg::INT_BITS;
   localparam int PIN_W = NW + 5;
   localparam int BL_W  = $clog2(BLINK_CYCLES + 1);

   if (LONG_PRESS_CYCLES <= DEBOUNCE_CYCLES || DEBOUNCE_CYCLES < 1 ||
       BLINK_CYCLES < 2 || NR * LW != 40 || NF * LW != 24) begin : g_check
      $error("power_button_wake_control: unsupported parameters");
   end

   function automatic logic isMapped(input logic [7:0] a);
      if (a == pwr_ctrl_pkg::CTRL_OFF || a == pwr_ctrl_pkg::CMD_OFF ||
          a == pwr_ctrl_pkg::STATE_OFF || a == pwr_ctrl_pkg::INT_EN_OFF ||
          a == pwr_ctrl_pkg::INT_STAT_OFF ||
          a == pwr_ctrl_pkg::INT_CLR_OFF || a == pwr_ctrl_pkg::FAN_CFG_OFF)
         return 1'b1;
      else if (a >= pwr_ctrl_pkg::RAIL_WIN_OFF &&
               a < pwr_ctrl_pkg::RAIL_WIN_OFF + 8'(4 * NR) &&
               a[1:0] == 2'b00)
         return 1'b1;
      else
         return 1'b0;
   endfunction : isMapped

   // Which wake sources a given state listens to
   function automatic logic [NW-1:0] wakeMask(
      input pwr_ctrl_pkg::pwr_state_t s,
      input logic s5Enable
   );
      logic [NW-1:0] m;
      m = '0;
      if (s != pwr_ctrl_pkg::PS_WORK) begin
         m[pwr_ctrl_pkg::WK_RTC]  = 1'b1;
         m[pwr_ctrl_pkg::WK_PCIE] = 1'b1;
         m[pwr_ctrl_pkg::WK_LAN]  = (s != pwr_ctrl_pkg::PS_OFF) || s5Enable;
         m[pwr_ctrl_pkg::WK_PME]  = (s != pwr_ctrl_pkg::PS_OFF) || s5Enable;
      end
      if (s == pwr_ctrl_pkg::PS_S1 || s == pwr_ctrl_pkg::PS_S3) begin
         m[pwr_ctrl_pkg::WK_RING] = 1'b1;
         m[pwr_ctrl_pkg::WK_KBD]  = 1'b1;
         m[pwr_ctrl_pkg::WK_USB]  = 1'b1;
      end
      return m;
   endfunction : wakeMask

   // Pin synchronisers; the A stage feeds only the B stage
   logic [PIN_W-1:0] syncA_reg, syncB_reg;
   logic [NW-1:0]    wakePrev_reg;
   logic             pressedSync, linkSync, actSync, speedSync, coverSync;
   logic [NW-1:0]    wakeSync, wakeEdge;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         syncA_reg    <= '0;
         syncB_reg    <= '0;
         wakePrev_reg <= '0;
      end else begin
         syncA_reg    <= {coverClosed, speed100, linkActivity, linkUp,
                          wakeIn, ~powerSwitch_n};
         syncB_reg    <= syncA_reg;
         wakePrev_reg <= wakeSync;
      end
   end

   assign pressedSync = syncB_reg[0];
   assign wakeSync    = syncB_reg[NW:1];
   assign linkSync    = syncB_reg[NW+1];
   assign actSync     = syncB_reg[NW+2];
   assign speedSync   = syncB_reg[NW+3];
   assign coverSync   = syncB_reg[NW+4];
   assign wakeEdge    = wakeSync & ~wakePrev_reg;

   logic shortPress, longPress;

   switch_debounce #(
      .DEBOUNCE_CYCLES (DEBOUNCE_CYCLES),
      .LONG_CYCLES     (LONG_PRESS_CYCLES)
   ) u_switch (
      .clock       (clock),
      .rst_n       (rst_n),
      .pressedSync (pressedSync),
      .shortPress  (shortPress),
      .longPress   (longPress)
   );

   // Register file
   logic [2:0]       ctrl_reg, ctrl_next;
   logic [NI-1:0]    intEn_reg, intEn_next;
   logic [NI-1:0]    intStat_reg, intStat_next;
   logic [15:0]      fanCfg_reg, fanCfg_next;
   logic [16*NR-1:0] railWin_reg, railWin_next;
   logic [31:0]      prdata_reg, prdata_next;
   logic             wrAcc, swSleep, swOff;
   logic [NI-1:0]    events;
   logic [LW*NR-1:0] railLow, railHigh;
   logic [NR-1:0]    railFlags, railPrev_reg;
   logic             intrPrev_reg;
   logic [NF-1:0]    fanFull_reg, fanFull_next;
   logic [LW*NF-1:0] fanDrive_reg, fanDrive_next;

   pwr_ctrl_pkg::pwr_state_t state_reg, state_next;
   logic [2:0] code_reg, code_next;
   logic       coldBoot_reg, coldBoot_next;
   logic       wakeOk;
   pwr_ctrl_pkg::pwr_state_t sleepTarget;

   assign wrAcc   = psel && penable && pwrite && isMapped(paddr);
   assign swSleep = wrAcc && paddr == pwr_ctrl_pkg::CMD_OFF &&
                    pwdata[pwr_ctrl_pkg::CMD_SLEEP_BIT];
   assign swOff   = wrAcc && paddr == pwr_ctrl_pkg::CMD_OFF &&
                    pwdata[pwr_ctrl_pkg::CMD_SOFT_OFF_BIT];

   always_comb begin
      ctrl_next   = ctrl_reg;
      intEn_next  = intEn_reg;
      fanCfg_next = fanCfg_reg;
      railWin_next = railWin_reg;
      prdata_next = prdata_reg;
      if (wrAcc) begin
         if (paddr == pwr_ctrl_pkg::CTRL_OFF)
            ctrl_next = pwdata[2:0];
         else if (paddr == pwr_ctrl_pkg::INT_EN_OFF)
            intEn_next = pwdata[NI-1:0];
         else if (paddr == pwr_ctrl_pkg::FAN_CFG_OFF)
            fanCfg_next = pwdata[15:0];
         else if (paddr >= pwr_ctrl_pkg::RAIL_WIN_OFF)
            railWin_next[16*((paddr - pwr_ctrl_pkg::RAIL_WIN_OFF) >> 2) +: 16]
               = pwdata[15:0];
      end
      // Events set in the same cycle as a clear survive it
      intStat_next = intStat_reg;
      if (wrAcc && paddr == pwr_ctrl_pkg::INT_CLR_OFF)
         intStat_next = intStat_reg & ~pwdata[NI-1:0];
      intStat_next = intStat_next | events;
      // Read data are captured in the setup cycle
      if (psel && !penable) begin
         prdata_next = 32'h0;
         if (paddr == pwr_ctrl_pkg::CTRL_OFF) begin
            prdata_next[2:0] = ctrl_reg;
         end else if (paddr == pwr_ctrl_pkg::STATE_OFF) begin
            prdata_next[pwr_ctrl_pkg::STATE_CODE_LSB +: 3] = code_reg;
            prdata_next[pwr_ctrl_pkg::STATE_INTRUDE_BIT]   = coverSync;
            prdata_next[pwr_ctrl_pkg::STATE_RAIL_LSB +: NR] = railFlags;
            prdata_next[pwr_ctrl_pkg::STATE_FAN_LSB +: NF] = fanFull_reg;
            prdata_next[pwr_ctrl_pkg::STATE_LINK_BIT]      = linkSync;
         end else if (paddr == pwr_ctrl_pkg::INT_STAT_OFF) begin
            prdata_next[NI-1:0] = intStat_reg;
         end else if (paddr == pwr_ctrl_pkg::INT_EN_OFF) begin
            prdata_next[NI-1:0] = intEn_reg;
         end else if (paddr == pwr_ctrl_pkg::FAN_CFG_OFF) begin
            prdata_next[15:0] = fanCfg_reg;
         end else if (isMapped(paddr) &&
                      paddr >= pwr_ctrl_pkg::RAIL_WIN_OFF) begin
            prdata_next[15:0] =
               railWin_reg[16*((paddr - pwr_ctrl_pkg::RAIL_WIN_OFF) >> 2) +: 16];
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ctrl_reg    <= pwr_ctrl_pkg::CTRL_RESET;
         intEn_reg   <= '0;
         intStat_reg <= '0;
         fanCfg_reg  <= pwr_ctrl_pkg::FAN_CFG_RESET;
         railWin_reg <= {NR{pwr_ctrl_pkg::RAIL_WIN_RESET}};
         prdata_reg  <= 32'h0;
      end else begin
         ctrl_reg    <= ctrl_next;
         intEn_reg   <= intEn_next;
         intStat_reg <= intStat_next;
         fanCfg_reg  <= fanCfg_next;
         railWin_reg <= railWin_next;
         prdata_reg  <= prdata_next;
      end
   end

   assign prdata  = prdata_reg;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !isMapped(paddr);
   assign irq     = |(intStat_reg & intEn_reg);

   // Power state machine
   always_comb begin
      case (ctrl_reg[pwr_ctrl_pkg::CTRL_SLEEP_LSB +: 2])
         2'h0:    sleepTarget = pwr_ctrl_pkg::PS_S1;
         2'h1:    sleepTarget = pwr_ctrl_pkg::PS_S3;
         default: sleepTarget = pwr_ctrl_pkg::PS_S4;
      endcase
      wakeOk = |(wakeEdge &
                 wakeMask(state_reg, ctrl_reg[pwr_ctrl_pkg::CTRL_S5_WAKE_BIT]));
      state_next = state_reg;
      case (state_reg)
         pwr_ctrl_pkg::PS_OFF: begin
            if (shortPress || wakeOk)
               state_next = pwr_ctrl_pkg::PS_WORK;
         end
         pwr_ctrl_pkg::PS_WORK: begin
            if (longPress)
               state_next = pwr_ctrl_pkg::PS_OFF;
            else if (shortPress || swSleep)
               state_next = sleepTarget;
            else if (swOff)
               state_next = pwr_ctrl_pkg::PS_OFF;
         end
         pwr_ctrl_pkg::PS_S1, pwr_ctrl_pkg::PS_S3, pwr_ctrl_pkg::PS_S4: begin
            if (longPress)
               state_next = pwr_ctrl_pkg::PS_OFF;
            else if (shortPress || wakeOk)
               state_next = pwr_ctrl_pkg::PS_WORK;
         end
         default: state_next = pwr_ctrl_pkg::PS_OFF;
      endcase
      case (state_next)
         pwr_ctrl_pkg::PS_WORK: code_next = 3'h0;
         pwr_ctrl_pkg::PS_S1:   code_next = 3'h1;
         pwr_ctrl_pkg::PS_S3:   code_next = 3'h3;
         pwr_ctrl_pkg::PS_S4:   code_next = 3'h4;
         default:               code_next = 3'h5;
      endcase
      // Leaving soft-off means nothing was saved
      coldBoot_next = state_reg == pwr_ctrl_pkg::PS_OFF &&
                      state_next == pwr_ctrl_pkg::PS_WORK;
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_reg    <= pwr_ctrl_pkg::PS_OFF;
         code_reg     <= 3'h5;
         coldBoot_reg <= 1'b0;
      end else begin
         state_reg    <= state_next;
         code_reg     <= code_next;
         coldBoot_reg <= coldBoot_next;
      end
   end

   assign sleepCode        = code_reg;
   assign stopGrant        = code_reg == 3'h1;
   assign selfRefresh      = code_reg == 3'h3;
   assign diskContext      = code_reg == 3'h4;
   assign coldBoot         = coldBoot_reg;
   assign devicePowerOn    = code_reg == 3'h0 || code_reg == 3'h1;
   assign wakeLogicPowerOn = rst_n;

   // Link LEDs; activity is stretched to a visible blink period
   logic [BL_W-1:0] blink_reg, blink_next;
   logic            phase_reg, phase_next;
   logic            actSeen_reg, actSeen_next;
   logic            tick;

   assign tick = blink_reg == BL_W'(BLINK_CYCLES - 1);

   always_comb begin
      blink_next   = tick ? '0 : blink_reg + BL_W'(1);
      actSeen_next = actSeen_reg;
      phase_next   = phase_reg;
      if (tick) begin
         phase_next   = actSeen_reg && !phase_reg;
         actSeen_next = 1'b0;
      end
      if (actSync)
         actSeen_next = 1'b1;
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         blink_reg   <= '0;
         phase_reg   <= 1'b0;
         actSeen_reg <= 1'b0;
      end else begin
         blink_reg   <= blink_next;
         phase_reg   <= phase_next;
         actSeen_reg <= actSeen_next;
      end
   end

   assign linkLedGreen   = linkSync && !phase_reg;
   assign speedLedYellow = speedSync;
   assign intrusion      = coverSync;

   // Supply rails
   for (genvar r = 0; r < NR; r++) begin : g_win
      assign railLow[r*LW +: LW]  =
         railWin_reg[16*r + pwr_ctrl_pkg::WIN_LOW_LSB +: LW];
      assign railHigh[r*LW +: LW] =
         railWin_reg[16*r + pwr_ctrl_pkg::WIN_HIGH_LSB +: LW];
   end

   window_compare #(
      .NUM (NR),
      .W   (LW)
   ) u_rails (
      .clock     (clock),
      .rst_n     (rst_n),
      .level     (railLevel),
      .lowLimit  (railLow),
      .highLimit (railHigh),
      .fault     (railFlags)
   );

   assign railFault = railFlags;

   // Fan control; fans only run while the board is in S0 or S1
   logic [LW-1:0] fanOff, fanFullT;
   assign fanOff   = fanCfg_reg[pwr_ctrl_pkg::FAN_OFF_LSB +: LW];
   assign fanFullT = fanCfg_reg[pwr_ctrl_pkg::FAN_FULL_LSB +: LW];

   for (genvar f = 0; f < NF; f++) begin : g_fan
      logic [LW-1:0] t, diff;
      logic [LW+1:0] scaled;
      assign t      = tempLevel[f*LW +: LW];
      assign diff   = t - fanOff;
      // Slope of four drive steps per degree keeps this a shift
      assign scaled = {diff, 2'b00};
      always_comb begin
         fanFull_next[f] = devicePowerOn && t >= fanFullT;
         if (!devicePowerOn || t <= fanOff)
            fanDrive_next[f*LW +: LW] = '0;
         else if (t >= fanFullT || scaled[LW+1:LW] != 2'b00)
            fanDrive_next[f*LW +: LW] = '1;
         else
            fanDrive_next[f*LW +: LW] = scaled[LW-1:0];
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         fanDrive_reg <= '0;
         fanFull_reg  <= '0;
         railPrev_reg <= '0;
         intrPrev_reg <= 1'b0;
      end else begin
         fanDrive_reg <= fanDrive_next;
         fanFull_reg  <= fanFull_next;
         railPrev_reg <= railFlags;
         intrPrev_reg <= coverSync;
      end
   end

   assign fanDrive = fanDrive_reg;

   always_comb begin
      events = '0;
      events[pwr_ctrl_pkg::INT_STATE_CHG]  = state_next != state_reg;
      events[pwr_ctrl_pkg::INT_INTRUSION]  = coverSync && !intrPrev_reg;
      events[pwr_ctrl_pkg::INT_RAIL]       = |(railFlags & ~railPrev_reg);
      events[pwr_ctrl_pkg::INT_FORCED_OFF] = longPress &&
                                             state_reg != pwr_ctrl_pkg::PS_OFF;
      events[pwr_ctrl_pkg::INT_THERMAL]    = |(fanFull_next & ~fanFull_reg);
   end

endmodule : power_button_wake_control

// *** verilog/pwr_ctrl_pkg.sv ***
package pwr_ctrl_pkg;

   // Timing, in printed units and derived cycle counts
   localparam int CLOCK_HZ          = 20_000_000;
   localparam int LONG_PRESS_MS     = 4000;
   localparam int LONG_PRESS_CYCLES = LONG_PRESS_MS * (CLOCK_HZ / 1000);
   localparam int DEBOUNCE_MS       = 20;
   localparam int DEBOUNCE_CYCLES   = DEBOUNCE_MS * (CLOCK_HZ / 1000);
   localparam int BLINK_MS          = 50;
   localparam int BLINK_CYCLES      = BLINK_MS * (CLOCK_HZ / 1000);

   // Sizes
   localparam int NUM_RAILS     = 5;
   localparam int NUM_FANS      = 3;
   localparam int LEVEL_W       = 8;
   localparam int WAKE_SOURCES  = 7;
   localparam int INT_BITS      = 5;

   // Register byte offsets
   localparam logic [7:0] CTRL_OFF     = 8'h00;
   localparam logic [7:0] CMD_OFF      = 8'h04;
   localparam logic [7:0] STATE_OFF    = 8'h08;
   localparam logic [7:0] INT_STAT_OFF = 8'h0c;
   localparam logic [7:0] INT_EN_OFF   = 8'h10;
   localparam logic [7:0] INT_CLR_OFF  = 8'h14;
   localparam logic [7:0] FAN_CFG_OFF  = 8'h18;
   localparam logic [7:0] RAIL_WIN_OFF = 8'h20;

   // Field positions
   localparam int CTRL_S5_WAKE_BIT  = 0;
   localparam int CTRL_SLEEP_LSB    = 1;
   localparam int CMD_SLEEP_BIT     = 0;
   localparam int CMD_SOFT_OFF_BIT  = 1;
   localparam int STATE_CODE_LSB    = 0;
   localparam int STATE_INTRUDE_BIT = 3;
   localparam int STATE_RAIL_LSB    = 4;
   localparam int STATE_FAN_LSB     = 9;
   localparam int STATE_LINK_BIT    = 12;
   localparam int FAN_OFF_LSB       = 0;
   localparam int FAN_FULL_LSB      = 8;
   localparam int WIN_LOW_LSB       = 0;
   localparam int WIN_HIGH_LSB      = 8;

   // Wake source indices
   localparam int WK_RTC  = 0;
   localparam int WK_PCIE = 1;
   localparam int WK_LAN  = 2;
   localparam int WK_PME  = 3;
   localparam int WK_RING = 4;
   localparam int WK_KBD  = 5;
   localparam int WK_USB  = 6;

   // Interrupt bit positions
   localparam int INT_STATE_CHG  = 0;
   localparam int INT_INTRUSION  = 1;
   localparam int INT_RAIL       = 2;
   localparam int INT_FORCED_OFF = 3;
   localparam int INT_THERMAL    = 4;

   // Reset values
   localparam logic [2:0]  CTRL_RESET     = 3'h0;
   localparam logic [15:0] FAN_CFG_RESET  = 16'h5028;
   localparam logic [15:0] RAIL_WIN_RESET = 16'hff00;

   typedef enum logic [2:0] {
      PS_WORK,
      PS_S1,
      PS_S3,
      PS_S4,
      PS_OFF
   } pwr_state_t;

endpackage : pwr_ctrl_pkg

// *** verilog/switch_debounce.sv ***
module switch_debounce #(
   parameter int DEBOUNCE_CYCLES = 400000,
   parameter int LONG_CYCLES     = 80000000
) (
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic pressedSync,
   output logic      shortPress,
   output logic      longPress
);
   localparam int DB_W   = $clog2(DEBOUNCE_CYCLES + 1);
   localparam int HOLD_W = $clog2(LONG_CYCLES + 1);

   logic              stable_reg, stable_next;
   logic [DB_W-1:0]   dbCount_reg, dbCount_next;
   logic [HOLD_W-1:0] hold_reg, hold_next;
   logic              longDone_reg, longDone_next;
   logic              short_reg, short_next;
   logic              long_reg, long_next;

   always_comb begin
      stable_next   = stable_reg;
      dbCount_next  = '0;
      hold_next     = hold_reg;
      longDone_next = longDone_reg;
      short_next    = 1'b0;
      long_next     = 1'b0;
      // Level must hold for the whole window before it is believed
      if (pressedSync != stable_reg) begin
         dbCount_next = dbCount_reg + DB_W'(1);
         if (dbCount_reg == DB_W'(DEBOUNCE_CYCLES - 1)) begin
            stable_next  = pressedSync;
            dbCount_next = '0;
         end
      end
      if (stable_reg && !longDone_reg) begin
         hold_next = hold_reg + HOLD_W'(1);
         if (hold_reg == HOLD_W'(LONG_CYCLES - 1)) begin
            long_next     = 1'b1;
            longDone_next = 1'b1;
         end
      end
      if (stable_reg && !stable_next) begin
         // A release after the long event is not a short press
         short_next    = !longDone_reg;
         hold_next     = '0;
         longDone_next = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         stable_reg   <= 1'b0;
         dbCount_reg  <= '0;
         hold_reg     <= '0;
         longDone_reg <= 1'b0;
         short_reg    <= 1'b0;
         long_reg     <= 1'b0;
      end else begin
         stable_reg   <= stable_next;
         dbCount_reg  <= dbCount_next;
         hold_reg     <= hold_next;
         longDone_reg <= longDone_next;
         short_reg    <= short_next;
         long_reg     <= long_next;
      end
   end

   assign shortPress = short_reg;
   assign longPress  = long_reg;

endmodule : switch_debounce

// *** verilog/window_compare.sv ***
module window_compare #(
   parameter int NUM = 5,
   parameter int W   = 8
) (
   input  wire logic           clock,
   input  wire logic           rst_n,
   input  wire logic [NUM*W-1:0] level,
   input  wire logic [NUM*W-1:0] lowLimit,
   input  wire logic [NUM*W-1:0] highLimit,
   output logic [NUM-1:0]      fault
);
   logic [NUM-1:0] fault_reg, fault_next;

   for (genvar i = 0; i < NUM; i++) begin : g_rail
      always_comb begin
         fault_next[i] = (level[i*W +: W] < lowLimit[i*W +: W]) ||
                         (level[i*W +: W] > highLimit[i*W +: W]);
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         fault_reg <= '0;
      end else begin
         fault_reg <= fault_next;
      end
   end

   assign fault = fault_reg;

endmodule : window_compare
